// file: design/cms_map.svh
/*
 * Register offsets, control bit positions, reset values and timing counts
 * of the configuration mode select block.
 * Assumes a 20 MHz system clock and byte addresses on a 32-bit bus.
 */
`ifndef CMS_MAP_SVH
`define CMS_MAP_SVH

`define CMS_OFS_CTRL     4'h0
`define CMS_OFS_STATUS   4'h4
`define CMS_OFS_ADDR     4'h8

`define CMS_CTRL_START   0
`define CMS_CTRL_STOP    1
`define CMS_CTRL_FAST    2
`define CMS_CTRL_WIDE    3
`define CMS_CTRL_LV      4
`define CMS_CTRL_MACRO   5
`define CMS_CTRL_UPINS   6
`define CMS_CTRL_PIN1    7
`define CMS_CTRL_RESET   8'h00
`define CMS_CTRL_WMASK   8'hfc

`define CMS_CLK_NS       50
`define CMS_SLOW_NS      1000
`define CMS_FAST_NS      125
`define CMS_SLOW_HALF    ((`CMS_SLOW_NS / 2) / `CMS_CLK_NS)
`define CMS_FAST_HALF    ((`CMS_FAST_NS / 2) / `CMS_CLK_NS)

`define CMS_ADDR_ASC     22'h00_0000
`define CMS_ADDR_DESC18  22'h03_ffff
`define CMS_ADDR_DESC22  22'h3f_ffff

`endif

// file: design/cms_pkg.sv
/*
 * Types of the configuration mode select block.
 * Assumes cms_map.svh carries the register, timing and address constants.
 */
package cms_pkg;

	// enum values are the mode pin codes themselves
	typedef enum logic [2:0] {
		CMS_MASTER_SERIAL = 3'h0,
		CMS_RSV_A         = 3'h1,
		CMS_RSV_B         = 3'h2,
		CMS_SYNC_PERIPH   = 3'h3,
		CMS_MASTER_UP     = 3'h4,
		CMS_ASYNC_PERIPH  = 3'h5,
		CMS_MASTER_DOWN   = 3'h6,
		CMS_SLAVE_SERIAL  = 3'h7
	} cms_mode_type;

	typedef enum logic [1:0] {
		CMS_IDLE = 2'h0,
		CMS_RUN  = 2'h1,
		CMS_DONE = 2'h3,
		CMS_HALT = 2'h2
	} cms_cfg_state_type;

	typedef enum logic [3:0] {
		TAP_TLR  = 4'h0, TAP_RTI  = 4'h1, TAP_SDS  = 4'h3, TAP_CDR  = 4'h2,
		TAP_SHDR = 4'h6, TAP_E1DR = 4'h7, TAP_UDR  = 4'h5, TAP_PDR  = 4'h4,
		TAP_E2DR = 4'hc, TAP_SIS  = 4'hd, TAP_CIR  = 4'hf, TAP_SHIR = 4'he,
		TAP_E1IR = 4'ha, TAP_UIR  = 4'hb, TAP_PIR  = 4'h9, TAP_E2IR = 4'h8
	} cms_tap_type;

	typedef enum logic [2:0] {
		IR_EXTEST = 3'h0, IR_SAMPLE = 3'h1, IR_USER1 = 3'h2, IR_USER2  = 3'h3,
		IR_RDBK   = 3'h4, IR_CONFIG = 3'h5, IR_RSV   = 3'h6, IR_BYPASS = 3'h7
	} cms_instr_type;

	typedef enum logic [1:0] {
		IO_FROM_DR = 2'h0, IO_FROM_PIN = 2'h1, IO_FROM_USER = 2'h2, IO_OFF = 2'h3
	} cms_io_src_type;

	typedef struct packed {
		logic [21:0] addr;
		logic        oe_lo_n;
		logic        oe_hi_n;
	} cms_prom_type;

	typedef struct packed {
		logic bit_val;
		logic bit_vld;
	} cms_stream_type;

endpackage : cms_pkg

// file: design/cms_top.sv
/*
 * Configuration mode select, config clock and PROM address generation,
 * byte serialiser and boundary-scan instruction decode with TAP.
 * Assumes an Avalon-MM master on CLK, pins arriving asynchronously and a
 * scan tester clocking TCK; frame parsing lives outside and reports
 * FIRST_FRAME. Boundary register shifting lives outside (BSR_TDO).
 */
// Overview of operation
// - mode pins sampled at start as 3-bit code
// - decode six modes, two codes reserved
// - all pins high selects slave serial
// - master and async peripheral drive clock out
// - ascending from zero, descending from top
// - parallel modes read byte, serialise bits
// - master serial clocks in serial bits
// - slow clock at start, fast in frame one
// - upper lines undriven until wide detected
// - low-voltage variant always drives all lines
// - upper lines part of one counter
// - mode pins user I/O after configuration
// - decode extest, sample, user1, user2 sources
// - decode readback, configure, reserved, bypass
// - no macro: scan off once configuration done
// - macro present: scan stays enabled
// - TMS high keeps TAP in reset
`timescale 1ns/10ps
`include "cms_map.svh"

module cms_top (
	// system
	input  wire logic                    CLK,
	input  wire logic                    SYS_RST,
	// register bus
	input  wire logic [3:0]              AVS_ADDRESS,
	input  wire logic                    AVS_READ,
	input  wire logic                    AVS_WRITE,
	input  wire logic [3:0]              AVS_BYTEENABLE,
	input  wire logic [31:0]             AVS_WRITEDATA,
	output logic      [31:0]             AVS_READDATA,
	output logic                         AVS_WAITREQUEST,
	// mode select pins
	input  wire logic                    MODE_SELECT_PIN_2,
	input  wire logic                    MODE_SELECT_PIN_1_I,
	input  wire logic                    MODE_SELECT_PIN_0,
	output logic                         MODE_SELECT_PIN_1_O,
	output logic                         MODE_SELECT_PIN_1_OE_N,
	output logic      [1:0]              USER_MODE_IN,
	// configuration link
	input  wire logic                    CONFIG_CLOCK_I,
	output logic                         CONFIG_CLOCK_O,
	output logic                         CONFIG_CLOCK_OE_N,
	input  wire logic                    CFG_DIN,
	input  wire logic [7:0]              PROM_DATA,
	output cms_pkg::cms_prom_type        PROM,
	input  wire logic                    FIRST_FRAME,
	output cms_pkg::cms_stream_type      CFG_STREAM,
	// scan port, TCK domain except SCAN_PINS_FREE, which is registered on CLK
	input  wire logic                    TCK,
	input  wire logic                    TMS,
	input  wire logic                    TDI,
	input  wire logic                    BSR_TDO,
	input  wire logic                    USER_SCAN_OUT_1,
	input  wire logic                    USER_SCAN_OUT_2,
	input  wire logic                    READBACK_DATA,
	input  wire logic                    CFG_DOUT,
	output logic                         TDO_O,
	output logic                         TDO_OE_N,
	output logic                         SCAN_SEL1,
	output logic                         SCAN_SEL2,
	output cms_pkg::cms_io_src_type      SCAN_IO_SRC,
	output logic                         SCAN_PINS_FREE
);
	import cms_pkg::*;

	// pin synchronisers: first stage feeds only the second
	logic [2:0]  mode_s1, mode_s2;
	logic        config_clock_s1, config_clock_s2, config_clock_d, din_s1, din_s2;
	logic [7:0]  data_s1, data_s2;
	always_ff @(posedge CLK) begin
		mode_s1 <= {MODE_SELECT_PIN_2, MODE_SELECT_PIN_1_I, MODE_SELECT_PIN_0};
		mode_s2 <= mode_s1;
		config_clock_s1 <= CONFIG_CLOCK_I;
		config_clock_s2 <= config_clock_s1;
		config_clock_d  <= config_clock_s2;
		din_s1  <= CFG_DIN;
		din_s2  <= din_s1;
		data_s1 <= PROM_DATA;
		data_s2 <= data_s1;
	end

	// register bus
	logic [7:0]        ctrl;
	logic              wr_go, start_p, stop_p;
	cms_cfg_state_type state;
	cms_mode_type      mode;
	logic              fast_act, wide_act;
	logic [21:0]       addr;
	logic [2:0]        ir_sys;
	logic              scan_en;
	logic [31:0]       rd_mux;

	assign wr_go   = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0]
		&& AVS_ADDRESS[3:2] == `CMS_OFS_CTRL >> 2;
	// start while running is refused, so it must not reset the datapath either
	assign start_p = wr_go && AVS_WRITEDATA[`CMS_CTRL_START] && state != CMS_RUN;
	assign stop_p  = wr_go && AVS_WRITEDATA[`CMS_CTRL_STOP];

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (AVS_ADDRESS[3:2])
			2'h0:    rd_mux = {24'h00_0000, ctrl};
			2'h1:    rd_mux = {21'h00_0000, scan_en, ir_sys, wide_act, fast_act,
				state, mode};
			2'h2:    rd_mux = {10'h000, addr};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// one wait cycle, then the answer stands for one cycle
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA    <= 32'h0000_0000;
		end else if ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST) begin
			AVS_WAITREQUEST <= 1'b0;
			AVS_READDATA    <= rd_mux;
		end else begin
			AVS_WAITREQUEST <= 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST)
			ctrl <= `CMS_CTRL_RESET;
		else if (wr_go)
			ctrl <= AVS_WRITEDATA[7:0] & `CMS_CTRL_WMASK;
	end

	// mode decode
	logic internal_clk, byte_mode, addr_mode, reserved, clk_tick;
	assign internal_clk = mode == CMS_MASTER_SERIAL || mode == CMS_MASTER_UP
		|| mode == CMS_MASTER_DOWN || mode == CMS_ASYNC_PERIPH;
	assign addr_mode = mode == CMS_MASTER_UP || mode == CMS_MASTER_DOWN;
	assign byte_mode = addr_mode || mode == CMS_SYNC_PERIPH || mode == CMS_ASYNC_PERIPH;
	assign reserved  = mode_s2 == CMS_RSV_A || mode_s2 == CMS_RSV_B;

	// configuration sequence; a new start is allowed after done or halt
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			state <= CMS_IDLE;
			mode  <= CMS_SLAVE_SERIAL;
		end else begin
			unique case (state)
				CMS_RUN:
					if (stop_p)
						state <= CMS_DONE;
				CMS_IDLE, CMS_DONE, CMS_HALT:
					if (start_p) begin
						mode  <= cms_mode_type'(mode_s2);
						state <= reserved ? CMS_HALT : CMS_RUN;
					end
			endcase
		end
	end

	// rate and width latch once per configuration
	always_ff @(posedge CLK) begin
		if (SYS_RST || start_p) begin
			fast_act <= 1'b0;
			wide_act <= 1'b0;
		end else if (state == CMS_RUN) begin
			fast_act <= fast_act || (ctrl[`CMS_CTRL_FAST] && FIRST_FRAME);
			wide_act <= wide_act || ctrl[`CMS_CTRL_WIDE];
		end
	end

	// config clock divider; fast rate rounds down to one cycle per half
	logic [3:0] div_cnt;
	logic       config_clock;
	always_ff @(posedge CLK) begin
		if (SYS_RST || state != CMS_RUN || !internal_clk) begin
			div_cnt <= 4'(`CMS_SLOW_HALF - 1);
			config_clock    <= 1'b0;
		end else if (div_cnt == 4'h0) begin
			div_cnt <= fast_act ? 4'(`CMS_FAST_HALF - 1) : 4'(`CMS_SLOW_HALF - 1);
			config_clock    <= !config_clock;
		end else begin
			div_cnt <= div_cnt - 4'h1;
		end
	end

	assign clk_tick = state == CMS_RUN && (internal_clk
		? (div_cnt == 4'h0 && !config_clock) : (config_clock_s2 && !config_clock_d));

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			CONFIG_CLOCK_O    <= 1'b0;
			CONFIG_CLOCK_OE_N <= 1'b1;
		end else begin
			CONFIG_CLOCK_O    <= config_clock;
			CONFIG_CLOCK_OE_N <= !(state == CMS_RUN && internal_clk);
		end
	end

	// serialiser, first bit of a byte is D0
	logic [7:0] shreg;
	logic [2:0] bit_idx;
	always_ff @(posedge CLK) begin
		if (SYS_RST || start_p) begin
			shreg      <= 8'h00;
			bit_idx    <= 3'h0;
			CFG_STREAM <= '0;
		end else if (clk_tick) begin
			CFG_STREAM.bit_vld <= 1'b1;
			if (!byte_mode) begin
				CFG_STREAM.bit_val <= din_s2;
			end else if (bit_idx == 3'h0) begin
				CFG_STREAM.bit_val <= data_s2[0];
				shreg              <= {1'b0, data_s2[7:1]};
			end else begin
				CFG_STREAM.bit_val <= shreg[0];
				shreg              <= {1'b0, shreg[7:1]};
			end
			bit_idx <= bit_idx + 3'h1;
		end else begin
			CFG_STREAM.bit_vld <= 1'b0;
		end
	end

	// one contiguous 22-bit counter; upper lines only gate the drivers
	always_ff @(posedge CLK) begin
		if (SYS_RST)
			addr <= `CMS_ADDR_ASC;
		else if (start_p)
			addr <= mode_s2 == CMS_MASTER_DOWN
				? ((AVS_WRITEDATA[`CMS_CTRL_LV] || AVS_WRITEDATA[`CMS_CTRL_WIDE])
					? `CMS_ADDR_DESC22 : `CMS_ADDR_DESC18)
				: `CMS_ADDR_ASC;
		else if (clk_tick && addr_mode && bit_idx == 3'h7)
			addr <= mode == CMS_MASTER_UP ? addr + 22'h00_0001 : addr - 22'h00_0001;
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			PROM <= {`CMS_ADDR_ASC, 1'b1, 1'b1};
		end else begin
			PROM.addr    <= addr;
			PROM.oe_lo_n <= !(state == CMS_RUN && addr_mode);
			PROM.oe_hi_n <= !(state == CMS_RUN && addr_mode
				&& (ctrl[`CMS_CTRL_LV] || wide_act));
		end
	end

	// mode pins as user I/O only once configured and asked for
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			MODE_SELECT_PIN_1_O    <= 1'b0;
			MODE_SELECT_PIN_1_OE_N <= 1'b1;
			USER_MODE_IN           <= 2'h0;
		end else begin
			MODE_SELECT_PIN_1_O    <= ctrl[`CMS_CTRL_PIN1];
			MODE_SELECT_PIN_1_OE_N <= !(state == CMS_DONE && ctrl[`CMS_CTRL_UPINS]);
			USER_MODE_IN <= (state == CMS_DONE && ctrl[`CMS_CTRL_UPINS])
				? {mode_s2[2], mode_s2[0]} : 2'h0;
		end
	end

	// scan lives through configuration, afterwards only with the macro
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			scan_en        <= 1'b1;
			SCAN_PINS_FREE <= 1'b0;
		end else begin
			scan_en        <= state != CMS_DONE || ctrl[`CMS_CTRL_MACRO];
			SCAN_PINS_FREE <= !(state != CMS_DONE || ctrl[`CMS_CTRL_MACRO]);
		end
	end

	// TCK domain: reset and enable brought across by two flops
	logic        rst_t1, rst_tck, en_t1, en_tck, bypass_reg, ir_tgl;
	cms_tap_type tap, next_tap;
	logic [2:0]  ir_sh;
	cms_instr_type ir;
	always_ff @(posedge TCK) begin
		rst_t1  <= SYS_RST;
		rst_tck <= rst_t1;
		en_t1   <= scan_en;
		en_tck  <= en_t1;
	end

	always_comb begin
		next_tap = tap;
		unique case (tap)
			TAP_TLR:  next_tap = TMS ? TAP_TLR  : TAP_RTI;
			TAP_RTI:  next_tap = TMS ? TAP_SDS  : TAP_RTI;
			TAP_SDS:  next_tap = TMS ? TAP_SIS  : TAP_CDR;
			TAP_CDR:  next_tap = TMS ? TAP_E1DR : TAP_SHDR;
			TAP_SHDR: next_tap = TMS ? TAP_E1DR : TAP_SHDR;
			TAP_E1DR: next_tap = TMS ? TAP_UDR  : TAP_PDR;
			TAP_PDR:  next_tap = TMS ? TAP_E2DR : TAP_PDR;
			TAP_E2DR: next_tap = TMS ? TAP_UDR  : TAP_SHDR;
			TAP_UDR:  next_tap = TMS ? TAP_SDS  : TAP_RTI;
			TAP_SIS:  next_tap = TMS ? TAP_TLR  : TAP_CIR;
			TAP_CIR:  next_tap = TMS ? TAP_E1IR : TAP_SHIR;
			TAP_SHIR: next_tap = TMS ? TAP_E1IR : TAP_SHIR;
			TAP_E1IR: next_tap = TMS ? TAP_UIR  : TAP_PIR;
			TAP_PIR:  next_tap = TMS ? TAP_E2IR : TAP_PIR;
			TAP_E2IR: next_tap = TMS ? TAP_UIR  : TAP_SHIR;
			TAP_UIR:  next_tap = TMS ? TAP_SDS  : TAP_RTI;
		endcase
	end

	// TMS high walks the standard graph back to reset and keeps it there
	always_ff @(posedge TCK) begin
		if (rst_tck || !en_tck)
			tap <= TAP_TLR;
		else
			tap <= next_tap;
	end

	always_ff @(posedge TCK) begin
		if (rst_tck || tap == TAP_TLR) begin
			ir_sh  <= 3'h7;
			ir     <= IR_BYPASS;
			ir_tgl <= 1'b0;
		end else if (tap == TAP_CIR) begin
			ir_sh <= 3'h1;
		end else if (tap == TAP_SHIR) begin
			ir_sh <= {TDI, ir_sh[2:1]};
		end else if (tap == TAP_UIR) begin
			ir     <= cms_instr_type'(ir_sh);
			ir_tgl <= !ir_tgl;
		end
	end

	always_ff @(posedge TCK) begin
		if (rst_tck)
			bypass_reg <= 1'b0;
		else if (tap == TAP_SHDR)
			bypass_reg <= TDI;
		else if (tap == TAP_CDR)
			bypass_reg <= 1'b0;
	end

	always_ff @(posedge TCK) begin
		if (rst_tck) begin
			SCAN_SEL1   <= 1'b0;
			SCAN_SEL2   <= 1'b0;
			SCAN_IO_SRC <= IO_FROM_PIN;
		end else begin
			SCAN_SEL1 <= ir == IR_USER1;
			SCAN_SEL2 <= ir == IR_USER2;
			unique case (ir)
				IR_EXTEST:           SCAN_IO_SRC <= IO_FROM_DR;
				IR_USER1, IR_USER2:  SCAN_IO_SRC <= IO_FROM_USER;
				IR_CONFIG:           SCAN_IO_SRC <= IO_OFF;
				default:             SCAN_IO_SRC <= IO_FROM_PIN;
			endcase
		end
	end

	// TDO changes on the falling edge so the tester samples it cleanly
	always_ff @(negedge TCK) begin
		if (rst_tck) begin
			TDO_O    <= 1'b0;
			TDO_OE_N <= 1'b1;
		end else if (tap == TAP_SHIR) begin
			TDO_O    <= ir_sh[0];
			TDO_OE_N <= 1'b0;
		end else if (tap == TAP_SHDR) begin
			TDO_OE_N <= ir == IR_RSV;
			unique case (ir)
				IR_EXTEST, IR_SAMPLE: TDO_O <= BSR_TDO;
				IR_USER1:             TDO_O <= USER_SCAN_OUT_1;
				IR_USER2:             TDO_O <= USER_SCAN_OUT_2;
				IR_RDBK:              TDO_O <= READBACK_DATA;
				IR_CONFIG:            TDO_O <= CFG_DOUT;
				default:              TDO_O <= bypass_reg;
			endcase
		end else begin
			TDO_OE_N <= 1'b1;
		end
	end

	// instruction crosses by toggle; it stays put for many TCK after update
	logic tgl_s1, tgl_s2, tgl_d;
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			tgl_s1 <= 1'b0;
			tgl_s2 <= 1'b0;
			tgl_d  <= 1'b0;
			ir_sys <= 3'h7;
		end else begin
			tgl_s1 <= ir_tgl;
			tgl_s2 <= tgl_s1;
			tgl_d  <= tgl_s2;
			if (tgl_s2 != tgl_d)
				ir_sys <= ir;
		end
	end

	// checks, system domain
	sequence s_start_run;
		start_p && state != CMS_RUN ##1 state == CMS_RUN;
	endsequence

	a_mode_sample: assert property (@(posedge CLK) disable iff (SYS_RST)
		start_p && state != CMS_RUN && !reserved |=> mode == $past(mode_s2))
		else $error("mode not taken from pins");
	a_all_high_slave: assert property (@(posedge CLK) disable iff (SYS_RST)
		start_p && state != CMS_RUN && mode_s2 == 3'h7 |=> mode == CMS_SLAVE_SERIAL)
		else $error("all-high pins not slave serial");
	a_asc_start: assert property (@(posedge CLK) disable iff (SYS_RST)
		s_start_run ##0 mode == CMS_MASTER_UP |-> addr == 22'h00_0000)
		else $error("ascending start wrong");
	a_desc_start: assert property (@(posedge CLK) disable iff (SYS_RST)
		s_start_run ##0 mode == CMS_MASTER_DOWN && !ctrl[4] && !ctrl[3]
		|-> addr == 22'h03_ffff)
		else $error("descending start wrong");
	a_slow_start: assert property (@(posedge CLK) disable iff (SYS_RST)
		s_start_run |-> !fast_act && div_cnt == 4'h9)
		else $error("clock not slow at start");
	a_clk_driven: assert property (@(posedge CLK) disable iff (SYS_RST)
		state == CMS_RUN && internal_clk ##1 state == CMS_RUN |-> !CONFIG_CLOCK_OE_N)
		else $error("config clock not driven");
	a_clk_input: assert property (@(posedge CLK) disable iff (SYS_RST)
		state == CMS_RUN && !internal_clk |=> CONFIG_CLOCK_OE_N)
		else $error("config clock driven in input mode");
	a_reserved_quiet: assert property (@(posedge CLK) disable iff (SYS_RST)
		state == CMS_HALT [*2] |-> CONFIG_CLOCK_OE_N && PROM.oe_lo_n && PROM.oe_hi_n)
		else $error("outputs driven on reserved code");
	a_upper_hidden: assert property (@(posedge CLK) disable iff (SYS_RST)
		!ctrl[4] && !wide_act |=> PROM.oe_hi_n)
		else $error("upper lines driven too early");
	a_lv_upper: assert property (@(posedge CLK) disable iff (SYS_RST)
		ctrl[4] && state == CMS_RUN && addr_mode |=> PROM.oe_hi_n == PROM.oe_lo_n)
		else $error("low-voltage upper lines not driven");
	a_byte_step: assert property (@(posedge CLK) disable iff (SYS_RST)
		clk_tick && mode == CMS_MASTER_UP && bit_idx == 3'h7
		|=> addr == $past(addr) + 22'h00_0001)
		else $error("address not stepped after byte");

	// checks, TCK domain
	a_tap_reset: assert property (@(posedge TCK) disable iff (rst_tck)
		TMS [*5] |=> tap == TAP_TLR)
		else $error("TAP not reset by TMS high");
	a_tdo_bypass: assert property (@(posedge TCK) disable iff (rst_tck)
		$past(tap) == TAP_SHDR && tap == TAP_SHDR && ir == IR_BYPASS
		|-> TDO_O == bypass_reg && !TDO_OE_N)
		else $error("bypass not on TDO");
	a_scan_off: assert property (@(posedge TCK) disable iff (rst_tck)
		!en_tck |=> tap == TAP_TLR)
		else $error("TAP active while released");

endmodule : cms_top

// file: dv/cms_prom_model.sv
/*
 * Far-side model: byte-wide configuration PROM plus serial PROM.
 * Assumes loader address and config clock are sampled on clk.
 */
`timescale 1ns/10ps
module cms_prom_model (
	// system
	input  wire logic                  clk,
	input  wire logic                  rst,
	// from the loader
	input  wire cms_pkg::cms_prom_type prom,
	input  wire logic                  cfg_clk,
	input  wire logic                  cfg_clk_oe_n,
	// to the loader
	output logic      [7:0]            prom_data,
	output logic                       ser_din
);
	import cms_pkg::*;
	localparam logic [7:0] SER_PAT = 8'hb2;
	logic [7:0] last;
	logic [2:0] idx;
	logic       cfg_clk_q;

	function automatic logic [7:0] rom(input logic [21:0] a);
		return a[7:0] ^ a[15:8] ^ {2'h0, a[21:16]} ^ 8'h5a;
	endfunction : rom

	// released bus shows the inverse, never a stale byte
	assign prom_data = prom.oe_lo_n ? ~last : rom(prom.addr);
	always_ff @(posedge clk) begin
		cfg_clk_q <= cfg_clk;
		if (rst)
			last <= 8'h00;
		else if (!prom.oe_lo_n)
			last <= rom(prom.addr);
	end
	// bits advance on falling config clock; idle line toggles
	always_ff @(posedge clk) begin
		if (rst || cfg_clk_oe_n) begin
			idx <= 3'h0;
			ser_din <= rst ? 1'b0 : ~ser_din;
		end else begin
			ser_din <= SER_PAT[idx];
			if (cfg_clk_q && !cfg_clk)
				idx <= idx + 3'h1;
		end
	end
endmodule : cms_prom_model

// file: dv/tb_top.sv
/*
 * Self-checking bench of the configuration mode select block.
 * Assumes cms_top and the PROM model; TCK free-running as tester clock.
 */
`timescale 1ns/10ps
`include "cms_map.svh"
module tb_top;
	import cms_pkg::*;
	logic           CLK = 1'b0, TCK = 1'b0, SYS_RST = 1'b1;
	logic [3:0]     AVS_ADDRESS = 4'h0, AVS_BYTEENABLE = 4'hf;
	logic           AVS_READ = 1'b0, AVS_WRITE = 1'b0, AVS_WAITREQUEST;
	logic [31:0]    AVS_WRITEDATA = 32'h0000_0000, AVS_READDATA;
	logic           MODE_SELECT_PIN_2 = 1'b1, MODE_SELECT_PIN_1_I = 1'b1;
	logic           MODE_SELECT_PIN_0 = 1'b1, MODE_SELECT_PIN_1_O, MODE_SELECT_PIN_1_OE_N;
	logic [1:0]     USER_MODE_IN;
	logic           CONFIG_CLOCK_I = 1'b0, CONFIG_CLOCK_O, CONFIG_CLOCK_OE_N, CFG_DIN;
	logic [7:0]     PROM_DATA;
	cms_prom_type   PROM;
	cms_stream_type CFG_STREAM;
	cms_io_src_type SCAN_IO_SRC;
	logic           FIRST_FRAME = 1'b0, TMS = 1'b1, TDI = 1'b0, BSR_TDO = 1'b0;
	logic           USER_SCAN_OUT_1 = 1'b0, USER_SCAN_OUT_2 = 1'b0, READBACK_DATA = 1'b0;
	logic           CFG_DOUT = 1'b0, TDO_O, TDO_OE_N, SCAN_SEL1, SCAN_SEL2, SCAN_PINS_FREE;
	logic [2:0]     div = 3'h0;
	logic [31:0]    st, r, seed = 32'h4ad3735d;
	int             miscompares = 0, n_tests = 0, cyc = 0, i;

	cms_top dut (.*);
	cms_prom_model u_prom (.clk(CLK), .rst(SYS_RST), .prom(PROM), .cfg_clk(CONFIG_CLOCK_O),
		.cfg_clk_oe_n(CONFIG_CLOCK_OE_N), .prom_data(PROM_DATA), .ser_din(CFG_DIN));

	always #25 CLK = ~CLK;
	always #7.5 TCK = ~TCK;
	// host clock for the modes that take the config clock in
	always @(posedge CLK) begin
		div <= div + 3'h1;
		CONFIG_CLOCK_I <= div[2];
	end
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 10000) begin
			miscompares++;
			close_out;
		end
	end

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// request raised after an edge, held until waitrequest is seen low;
	// only the bench timeout ends a hung wait
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
			output logic [31:0] q);
		@(posedge CLK);
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= d;
		AVS_WRITE <= wr;
		AVS_READ <= ~wr;
		do
			@(posedge CLK);
		while (AVS_WAITREQUEST !== 1'b0);
		q = AVS_READDATA;
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
	endtask : bus

	task automatic pins(input logic [2:0] m);
		@(posedge CLK);
		{MODE_SELECT_PIN_2, MODE_SELECT_PIN_1_I, MODE_SELECT_PIN_0} <= m;
		repeat (4) @(posedge CLK);
	endtask : pins

	task automatic tap(input logic ms, input logic di);
		@(posedge TCK);
		TMS <= ms;
		TDI <= di;
	endtask : tap

	task automatic tap_rst;
		repeat (5) tap(1'b1, 1'b0);
		tap(1'b0, 1'b0);
	endtask : tap_rst

	// instruction shifted lsb first, ends back in run-test/idle
	task automatic load_ir(input logic [2:0] ir);
		tap(1'b1, 1'b0);
		tap(1'b1, 1'b0);
		tap(1'b0, 1'b0);
		tap(1'b0, 1'b0);
		tap(1'b0, ir[0]);
		tap(1'b0, ir[1]);
		tap(1'b1, ir[2]);
		tap(1'b1, 1'b0);
		tap(1'b0, 1'b0);
		repeat (3) @(posedge TCK);
	endtask : load_ir

	function automatic logic par(input logic [2:0] m);
		return m == 3'h4 || m == 3'h6;
	endfunction : par

	function automatic logic rsv(input logic [2:0] m);
		return m == 3'h1 || m == 3'h2;
	endfunction : rsv

	function automatic logic [21:0] first_addr(input logic [2:0] m, input logic wd);
		return (m == 3'h4) ? `CMS_ADDR_ASC : wd ? `CMS_ADDR_DESC22 : `CMS_ADDR_DESC18;
	endfunction : first_addr

	function automatic logic [1:0] io_src(input logic [2:0] ir);
		case (ir)
			3'h0: return 2'h0;
			3'h2, 3'h3: return 2'h2;
			3'h5: return 2'h3;
			default: return 2'h1;
		endcase
	endfunction : io_src

	function automatic logic exp_tdo(input logic [2:0] ir);
		case (ir)
			3'h2: return USER_SCAN_OUT_1;
			3'h3: return USER_SCAN_OUT_2;
			3'h4: return READBACK_DATA;
			3'h5: return CFG_DOUT;
			3'h7: return 1'b0;
			default: return BSR_TDO;
		endcase
	endfunction : exp_tdo

	// fast rate allowed only once the first frame is flagged
	task automatic run_bytes(input logic [2:0] m, input logic [7:0] ctl, input logic ff,
			input int gap_exp);
		logic [7:0]  b;
		logic [21:0] a0;
		int          w, k;
		begin
			a0 = first_addr(m, ctl[3] | ctl[4]);
			pins(m);
			bus(1'b1, `CMS_OFS_CTRL, {24'h00_0000, ctl | 8'h01}, st);
			for (k = 0; k < 8; k++) begin
				w = 0;
				do begin
					@(posedge CLK);
					w++;
				end while (CFG_STREAM.bit_vld !== 1'b1 && w < 60);
				b[k] = CFG_STREAM.bit_val;
				if (k == 0)
					FIRST_FRAME <= ff;
			end
			chk("clk_period", w, gap_exp);
			if (m == 3'h0)
				chk("ser_bits", b, u_prom.SER_PAT);
			if (par(m))
				chk("byte_bits", b, u_prom.rom(a0));
			repeat (4) @(posedge CLK);
			if (par(m))
				chk("next_addr", PROM.addr, (m == 3'h4) ? a0 + 22'h1 : a0 - 22'h1);
			bus(1'b1, `CMS_OFS_CTRL, 32'h0000_0002, st);
			FIRST_FRAME <= 1'b0;
			$display("byte run mode %0d done", m);
		end
	endtask : run_bytes

	initial begin
		repeat (16) @(posedge CLK);
		SYS_RST <= 1'b0;
		@(posedge CLK);
		chk("wait_idle", AVS_WAITREQUEST, 1'b1);
		chk("config_clock_oe_rst", CONFIG_CLOCK_OE_N, 1'b1);
		chk("oe_hi_rst", PROM.oe_hi_n, 1'b1);
		chk("pin1_oe_rst", MODE_SELECT_PIN_1_OE_N, 1'b1);
		bus(1'b0, 4'hc, 32'h0000_0000, st);
		chk("unmapped", st, 32'h0000_0000);
		AVS_BYTEENABLE <= 4'h0;
		bus(1'b1, `CMS_OFS_CTRL, 32'h0000_0001, st);
		AVS_BYTEENABLE <= 4'hf;
		bus(1'b0, `CMS_OFS_STATUS, 32'h0000_0000, st);
		chk("be_refused", st[4:3], 2'h0);
		$display("reset test done");
		tap_rst;
		for (i = 0; i < 8; i++) begin
			r = $random(seed);
			@(posedge TCK);
			{BSR_TDO, USER_SCAN_OUT_1, USER_SCAN_OUT_2, READBACK_DATA, CFG_DOUT} <= r[4:0];
			load_ir(i[2:0]);
			chk("sel1", SCAN_SEL1, i == 2);
			chk("sel2", SCAN_SEL2, i == 3);
			if (i != 7)
				chk("io_src", SCAN_IO_SRC, io_src(i[2:0]));
			// toggle crossing needs three system clocks to land
			repeat (4) @(posedge CLK);
			bus(1'b0, `CMS_OFS_STATUS, 32'h0000_0000, st);
			chk("instr", st[9:7], i);
			tap(1'b1, 1'b0);
			tap(1'b0, 1'b0);
			tap(1'b0, 1'b0);
			repeat (2) @(posedge TCK);
			chk("tdo_oe", TDO_OE_N, i == 6);
			if (i != 6)
				chk("tdo", TDO_O, exp_tdo(i[2:0]));
			tap_rst;
		end
		load_ir(3'h2);
		tap_rst;
		repeat (2) @(posedge TCK);
		chk("sel1_tlr", SCAN_SEL1, 1'b0);
		tap(1'b1, 1'b0);
		$display("scan test done");
		for (i = 0; i < 16; i++) begin
			r = $random(seed);
			pins(i[2:0]);
			bus(1'b1, `CMS_OFS_CTRL, {27'h0, r[0], i[3], 3'h1}, st);
			bus(1'b0, `CMS_OFS_STATUS, 32'h0000_0000, st);
			chk("mode", st[2:0], i[2:0]);
			chk("state", st[4:3], rsv(i[2:0]) ? 2'h2 : 2'h1);
			chk("scan_on", st[10], 1'b1);
			chk("config_clock_oe", CONFIG_CLOCK_OE_N, !(par(i[2:0]) || i[2:0] inside {0, 5}));
			chk("oe_lo", PROM.oe_lo_n, !par(i[2:0]));
			chk("oe_hi", PROM.oe_hi_n, !(par(i[2:0]) && (i[3] || r[0])));
			if (par(i[2:0]))
				chk("addr0", PROM.addr, first_addr(i[2:0], i[3] | r[0]));
			bus(1'b1, `CMS_OFS_CTRL, 32'h0000_0002, st);
			bus(1'b0, `CMS_OFS_STATUS, 32'h0000_0000, st);
			if (!rsv(i[2:0])) begin
				chk("done", st[4:3], 2'h3);
				chk("scan_off", st[10], 1'b0);
				chk("pins_free", SCAN_PINS_FREE, 1'b1);
			end
		end
		tap_rst;
		load_ir(3'h2);
		chk("sel1_off", SCAN_SEL1, 1'b0);
		$display("mode test done");
		pins(3'h7);
		bus(1'b1, `CMS_OFS_CTRL, 32'h0000_00e1, st);
		bus(1'b1, `CMS_OFS_CTRL, 32'h0000_00e2, st);
		r = $random(seed);
		pins({r[1], 1'b1, r[0]});
		chk("user_in", USER_MODE_IN, r[1:0]);
		chk("pin1_oe", MODE_SELECT_PIN_1_OE_N, 1'b0);
		chk("pin1_o", MODE_SELECT_PIN_1_O, 1'b1);
		chk("pins_kept", SCAN_PINS_FREE, 1'b0);
		tap_rst;
		load_ir(3'h2);
		chk("sel1_macro", SCAN_SEL1, 1'b1);
		$display("user pin test done");
		run_bytes(3'h0, 8'h04, 1'b0, 20);
		run_bytes(3'h4, 8'h04, 1'b1, 2);
		run_bytes(3'h6, 8'h0c, 1'b1, 2);
		run_bytes(3'h7, 8'h00, 1'b0, 8);
		close_out;
	end
endmodule : tb_top
